// ---- design/asp_pkg.sv ----
// package: register map, field positions and frame constants
package asp_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ASP_CTRL_ADDR  = 8'h98;
    localparam logic [7:0] ASP_DATA_ADDR  = 8'h99;
    localparam logic [7:0] ASP_CTRL_RESET = 8'h40;
    localparam logic [7:0] ASP_DATA_RESET = 8'h00;

    // ****************************************
    // control fields
    // ****************************************
    localparam int ASP_FRAME_SEL_BIT = 7;
    localparam int ASP_UNUSED_BIT    = 6;
    localparam int ASP_MP_CHECK_BIT  = 5;
    localparam int ASP_RX_EN_BIT     = 4;
    localparam int ASP_TX_NINTH_BIT  = 3;
    localparam int ASP_RX_NINTH_BIT  = 2;
    localparam int ASP_TX_DONE_BIT   = 1;
    localparam int ASP_RX_DONE_BIT   = 0;

    // ****************************************
    // frame and timer constants
    // ****************************************
    localparam int          ASP_DATA_BITS   = 8;
    localparam logic [3:0]  ASP_LAST_DATA   = 4'h7;
    localparam int          ASP_TIMER_WRAP  = 256;
    localparam logic [7:0]  ASP_TIMER_TOP   = 8'hFF;
    localparam int          ASP_FIFO_DEPTH  = 8;

    typedef enum logic [4:0] {
        ASP_TX_IDLE  = 5'b00001,
        ASP_TX_START = 5'b00010,
        ASP_TX_DATA  = 5'b00100,
        ASP_TX_NINTH = 5'b01000,
        ASP_TX_STOP  = 5'b10000
    } asp_tx_state_t;

    typedef enum logic [4:0] {
        ASP_RX_IDLE  = 5'b00001,
        ASP_RX_START = 5'b00010,
        ASP_RX_DATA  = 5'b00100,
        ASP_RX_NINTH = 5'b01000,
        ASP_RX_STOP  = 5'b10000
    } asp_rx_state_t;

endpackage

// ---- design/asp_baud_timer.sv ----
// eight-bit auto-reload timer producing one overflow pulse per wrap
`timescale 1ns/1ps
module asp_baud_timer
    import asp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic [7:0] reload,
    input  wire logic       forceLoad,
    output logic            overflow
);

    logic [7:0] count_q;

    // ****************************************
    // counter
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 8'h00;
        end else if (forceLoad) begin
            count_q <= reload;
        end else if (tick) begin
            if (count_q == ASP_TIMER_TOP) begin
                count_q <= reload;
            end else begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    assign overflow = tick && !forceLoad && (count_q == ASP_TIMER_TOP);

endmodule

// ---- design/asp_fifo.sv ----
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module asp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // elaboration check: pointers wrap only for a power-of-two depth
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("fifo depth must be a power of two, width at least one");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem_q[rdPtr_q];

    // ****************************************
    // storage
    // ****************************************
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    // ****************************************
    // pointers and fill level
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + AW'(1);
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + AW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end

endmodule

// ---- design/asp_serial_port.sv ----
// full-duplex asynchronous serial port with 8-bit and 9-bit frames
`timescale 1ns/1ps
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int FIFO_DEPTH = ASP_FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrRdEn,
    output logic      [7:0] sfrRdData,
    output logic            txAccept,
    input  wire logic       timerTick,
    input  wire logic [7:0] baudReloadValue,
    input  wire logic       rxPin,
    output logic            txPin,
    output logic            irq
);

    // elaboration check: the transmit fifo needs a power-of-two depth
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
        $error("fifo depth must be a power of two, at least two");
    end


    // ****************************************
    // control and data registers
    // ****************************************
    logic       frameLengthSelect_q;
    logic       multiprocCheckEnable_q;
    logic       rxEnableCtl_q;
    logic       txNinthBit_q;
    logic       rxNinthBit_q;
    logic       txDoneFlag_q;
    logic       rxDoneFlag_q;
    logic [7:0] rxBuffer_q;
    logic       ctrlWr;
    logic       dataWr;
    logic       txDoneSet;
    logic       rxLoad;
    logic       rxLoadNinth;

    assign ctrlWr = sfrWrEn && (sfrAddr == ASP_CTRL_ADDR);
    assign dataWr = sfrWrEn && (sfrAddr == ASP_DATA_ADDR);

    always_ff @(posedge clk) begin
        if (rst) begin
            frameLengthSelect_q    <= ASP_CTRL_RESET[ASP_FRAME_SEL_BIT];
            multiprocCheckEnable_q <= ASP_CTRL_RESET[ASP_MP_CHECK_BIT];
            rxEnableCtl_q          <= ASP_CTRL_RESET[ASP_RX_EN_BIT];
            txNinthBit_q           <= ASP_CTRL_RESET[ASP_TX_NINTH_BIT];
        end else if (ctrlWr) begin
            frameLengthSelect_q    <= sfrWrData[ASP_FRAME_SEL_BIT];
            multiprocCheckEnable_q <= sfrWrData[ASP_MP_CHECK_BIT];
            rxEnableCtl_q          <= sfrWrData[ASP_RX_EN_BIT];
            txNinthBit_q           <= sfrWrData[ASP_TX_NINTH_BIT];
        end
    end

    // hardware set wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            txDoneFlag_q <= ASP_CTRL_RESET[ASP_TX_DONE_BIT];
        end else if (txDoneSet) begin
            txDoneFlag_q <= 1'b1;
        end else if (ctrlWr) begin
            txDoneFlag_q <= sfrWrData[ASP_TX_DONE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxDoneFlag_q <= ASP_CTRL_RESET[ASP_RX_DONE_BIT];
        end else if (rxLoad) begin
            rxDoneFlag_q <= 1'b1;
        end else if (ctrlWr) begin
            rxDoneFlag_q <= sfrWrData[ASP_RX_DONE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxNinthBit_q <= ASP_CTRL_RESET[ASP_RX_NINTH_BIT];
        end else if (rxLoad) begin
            rxNinthBit_q <= rxLoadNinth;
        end else if (ctrlWr) begin
            rxNinthBit_q <= sfrWrData[ASP_RX_NINTH_BIT];
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            sfrRdData <= 8'h00;
        end else if (sfrRdEn) begin
            if (sfrAddr == ASP_CTRL_ADDR) begin
                sfrRdData <= {frameLengthSelect_q, 1'b1,
                              multiprocCheckEnable_q, rxEnableCtl_q,
                              txNinthBit_q, rxNinthBit_q,
                              txDoneFlag_q, rxDoneFlag_q};
            end else if (sfrAddr == ASP_DATA_ADDR) begin
                sfrRdData <= rxBuffer_q;
            end else begin
                sfrRdData <= 8'h00;
            end
        end
    end

    assign irq = txDoneFlag_q || rxDoneFlag_q;

    // ****************************************
    // baud timers
    // ****************************************
    logic txOvf;
    logic rxOvf;
    logic rxRestart;
    logic txHalf_q;
    logic txBitTick;

    asp_baud_timer u_txTimer (
        .clk       (clk),
        .rst       (rst),
        .tick      (timerTick),
        .reload    (baudReloadValue),
        .forceLoad (1'b0),
        .overflow  (txOvf)
    );

    asp_baud_timer u_rxTimer (
        .clk       (clk),
        .rst       (rst),
        .tick      (timerTick),
        .reload    (baudReloadValue),
        .forceLoad (rxRestart),
        .overflow  (rxOvf)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            txHalf_q <= 1'b0;
        end else if (txOvf) begin
            txHalf_q <= ~txHalf_q;
        end
    end

    assign txBitTick = txOvf && txHalf_q;

    // ****************************************
    // transmit path
    // ****************************************
    logic          fifoValid;
    logic          fifoPop;
    logic [7:0]    fifoData;
    asp_tx_state_t txState_q;
    logic [7:0]    txShift_q;
    logic [3:0]    txCount_q;
    logic          txNinth_q;

    asp_fifo #(
        .WIDTH (ASP_DATA_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_txFifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (dataWr),
        .inReady  (txAccept),
        .inData   (sfrWrData),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    assign fifoPop   = (txState_q == ASP_TX_IDLE) && fifoValid && txBitTick;
    assign txDoneSet = txBitTick && (((txState_q == ASP_TX_DATA)
                       && (txCount_q == ASP_LAST_DATA)
                       && !frameLengthSelect_q)
                       || (txState_q == ASP_TX_NINTH));

    always_ff @(posedge clk) begin
        if (rst) begin
            txState_q <= ASP_TX_IDLE;
            txShift_q <= ASP_DATA_RESET;
            txCount_q <= 4'h0;
            txNinth_q <= 1'b1;
        end else if (txBitTick) begin
            unique case (txState_q)
                ASP_TX_IDLE: begin
                    if (fifoValid) begin
                        txShift_q <= fifoData;
                        txNinth_q <= txNinthBit_q;
                        txState_q <= ASP_TX_START;
                    end
                end
                ASP_TX_START: begin
                    txCount_q <= 4'h0;
                    txState_q <= ASP_TX_DATA;
                end
                ASP_TX_DATA: begin
                    txShift_q <= {1'b0, txShift_q[7:1]};
                    txCount_q <= txCount_q + 4'h1;
                    if (txCount_q == ASP_LAST_DATA) begin
                        txState_q <= frameLengthSelect_q ? ASP_TX_NINTH
                                                         : ASP_TX_STOP;
                    end
                end
                ASP_TX_NINTH: begin
                    txState_q <= ASP_TX_STOP;
                end
                ASP_TX_STOP: begin
                    txState_q <= ASP_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txPin <= 1'b1;
        end else begin
            unique case (txState_q)
                ASP_TX_IDLE:  txPin <= 1'b1;
                ASP_TX_START: txPin <= 1'b0;
                ASP_TX_DATA:  txPin <= txShift_q[0];
                ASP_TX_NINTH: txPin <= txNinth_q;
                ASP_TX_STOP:  txPin <= 1'b1;
            endcase
        end
    end

    // ****************************************
    // receive path
    // ****************************************
    asp_rx_state_t rxState_q;
    logic          rxPrev_q;
    logic          rxPhase_q;
    logic          rxSample;
    logic [7:0]    rxShift_q;
    logic [3:0]    rxCount_q;
    logic          rxNinth_q;
    logic          rxQualify;

    always_ff @(posedge clk) begin
        if (rst) begin
            rxPrev_q <= 1'b1;
        end else begin
            rxPrev_q <= rxPin;
        end
    end

    assign rxRestart = (rxState_q == ASP_RX_IDLE) && rxEnableCtl_q
                       && rxPrev_q && !rxPin;
    assign rxSample  = rxOvf && !rxPhase_q;

    always_ff @(posedge clk) begin
        if (rst || rxRestart) begin
            rxPhase_q <= 1'b0;
        end else if (rxOvf) begin
            rxPhase_q <= ~rxPhase_q;
        end
    end

    // 8-bit: stop must be 1 under check; 9-bit: ninth must be 1 under check
    always_comb begin
        if (frameLengthSelect_q) begin
            rxQualify = !multiprocCheckEnable_q || rxNinth_q;
        end else begin
            rxQualify = !multiprocCheckEnable_q || rxPin;
        end
    end

    assign rxLoad = (rxState_q == ASP_RX_STOP) && rxSample
                    && !rxDoneFlag_q && rxQualify;
    assign rxLoadNinth = frameLengthSelect_q ? rxNinth_q
                                             : rxPin;

    always_ff @(posedge clk) begin
        if (rst) begin
            rxBuffer_q <= ASP_DATA_RESET;
        end else if (rxLoad) begin
            rxBuffer_q <= rxShift_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxState_q <= ASP_RX_IDLE;
            rxShift_q <= 8'h00;
            rxCount_q <= 4'h0;
            rxNinth_q <= 1'b0;
        end else if (rxRestart) begin
            rxState_q <= ASP_RX_START;
        end else if (rxSample) begin
            unique case (rxState_q)
                ASP_RX_IDLE: begin
                    rxState_q <= ASP_RX_IDLE;
                end
                ASP_RX_START: begin
                    rxCount_q <= 4'h0;
                    rxState_q <= rxPin ? ASP_RX_IDLE : ASP_RX_DATA;
                end
                ASP_RX_DATA: begin
                    rxShift_q <= {rxPin, rxShift_q[7:1]};
                    rxCount_q <= rxCount_q + 4'h1;
                    if (rxCount_q == ASP_LAST_DATA) begin
                        rxState_q <= frameLengthSelect_q ? ASP_RX_NINTH
                                                         : ASP_RX_STOP;
                    end
                end
                ASP_RX_NINTH: begin
                    rxNinth_q <= rxPin;
                    rxState_q <= ASP_RX_STOP;
                end
                ASP_RX_STOP: begin
                    rxState_q <= ASP_RX_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- verif/asp_serial_port_properties.sv ----
// checker: port-level properties of the serial port
`timescale 1ns/1ps
module asp_serial_port_checker
    import asp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrRdEn,
    input  wire logic [7:0] sfrRdData,
    input  wire logic       txPin,
    input  wire logic       irq
);
    // ****
    // helpers
    // ****
    logic [7:0] ctrlWr_q;
    logic       ctrlRd;
    logic       ctrlWr;
    logic       badRd;
    assign ctrlRd = sfrRdEn && sfrAddr == ASP_CTRL_ADDR;
    assign ctrlWr = sfrWrEn && sfrAddr == ASP_CTRL_ADDR;
    assign badRd  = sfrRdEn && sfrAddr != ASP_CTRL_ADDR
                    && sfrAddr != ASP_DATA_ADDR;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlWr_q <= ASP_CTRL_RESET;
        end else if (ctrlWr) begin
            ctrlWr_q <= sfrWrData;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****
    // properties
    // ****
    AST_BIT6_ONE: assert property (ctrlRd |=> sfrRdData[6])
        else $error("unused control bit read as zero");
    AST_CTRL_BACK: assert property (ctrlRd && !ctrlWr |=>
        sfrRdData[7:3] == {ctrlWr_q[7], 1'b1, ctrlWr_q[5:3]})
        else $error("control fields differ from last write");
    AST_RD_HOLD: assert property (!sfrRdEn |=> $stable(sfrRdData))
        else $error("read data changed without a read");
    AST_UNMAPPED: assert property (badRd |=> sfrRdData == 8'h00)
        else $error("unmapped read not zero");
    AST_IRQ_FLAGS: assert property (ctrlRd |=>
        (|sfrRdData[1:0]) == $past(irq))
        else $error("interrupt request disagrees with done flags");
    AST_FLAG_STICKY: assert property (irq && !ctrlWr |=> irq)
        else $error("done flag cleared without software write");
    AST_TX_LOW_RUN: assert property ($fell(txPin) |-> !txPin[*8])
        else $error("low bit on line shorter than a bit period");
    AST_TX_HIGH_RUN: assert property ($rose(txPin) |-> txPin[*8])
        else $error("high bit on line shorter than a bit period");
endmodule

bind asp_serial_port asp_serial_port_checker asp_serial_port_checker_i (
    .clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .txPin(txPin), .irq(irq)
);

// ---- verif/asp_remote_model.sv ----
// remote serial transceiver model on the far side of the line
`timescale 1ns/1ps
module asp_remote_model #(
    parameter int BIT_CLKS = 8
) (
    input  wire logic clk,
    input  wire logic serIn,
    input  wire logic nineBit,
    output logic      serOut
);
    logic [8:0] gotQ[$];
    logic [8:0] shift;
    logic       prevIn;
    initial begin
        serOut = 1'b1;
        prevIn = 1'b1;
    end
    // ****
    // sender, line idles high between frames
    // ****
    task automatic send(input logic [7:0] d, input logic nine,
                        input logic ninth, input logic stopLvl);
        logic [10:0] frm;
        frm = nine ? {stopLvl, ninth, d, 1'b0}
                   : {1'b1, stopLvl, d, 1'b0};
        @(posedge clk);
        #1;
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            serOut = frm[i];
            repeat (BIT_CLKS) @(posedge clk);
            #1;
        end
        serOut = 1'b1;
    endtask
    // ****
    // receiver, samples mid-bit, keeps stop or ninth in bit 8
    // ****
    always begin
        @(posedge clk);
        if (prevIn && !serIn) begin
            repeat (BIT_CLKS / 2) @(posedge clk);
            if (!serIn) begin
                for (int i = 0; i < 9; i++) begin
                    repeat (BIT_CLKS) @(posedge clk);
                    shift[i] = serIn;
                end
                if (nineBit) begin
                    repeat (BIT_CLKS) @(posedge clk);
                end
                gotQ.push_back(shift);
            end
        end
        prevIn = serIn;
    end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the serial port
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            fail_count++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module tb;
    import asp_pkg::*;
    localparam int BIT = 8;
    localparam logic [12:0] CASE_TBL [7] = '{
        {8'h00, 5'b00100}, {8'h30, 5'b00000}, {8'h30, 5'b00111},
        {8'h10, 5'b00010}, {8'hB0, 5'b10000}, {8'hB0, 5'b11011},
        {8'h90, 5'b10110}};
    logic        clk;
    logic        rst;
    logic        sfrWrEn;
    logic        sfrRdEn;
    logic        timerTick;
    logic        rxPin;
    logic        txPin;
    logic        irq;
    logic        txAccept;
    logic        nineMode;
    logic [7:0]  sfrAddr;
    logic [7:0]  sfrWrData;
    logic [7:0]  sfrRdData;
    logic [7:0]  baudReloadValue;
    logic [7:0]  v;
    logic [7:0]  b;
    logic [7:0]  held;
    logic [8:0]  got;
    logic [12:0] c;
    int          fail_count;
    int          check_count;
    int          n;
    int          seed;
    asp_serial_port #(.FIFO_DEPTH(8)) asp_serial_port_i (
        .clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
        .txAccept(txAccept), .timerTick(timerTick),
        .baudReloadValue(baudReloadValue), .rxPin(rxPin), .txPin(txPin),
        .irq(irq));
    asp_remote_model #(.BIT_CLKS(BIT)) asp_remote_model_i (
        .clk(clk), .serIn(txPin), .nineBit(nineMode), .serOut(rxPin));
    always #2.5 clk = ~clk;
    // ****
    // bus tasks
    // ****
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(posedge clk);
        #1;
        sfrWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(posedge clk);
        #1;
        sfrRdEn = 1'b0;
        d = sfrRdData;
    endtask
    // waits for irq when qn is 0, else for qn captured frames
    task automatic wait_for(input int qn, input int lim);
        int k;
        k = 0;
        while ((qn == 0 ? irq !== 1'b1
                : asp_remote_model_i.gotQ.size() < qn) && k < lim) begin
            @(posedge clk);
            #1;
            k++;
        end
        `CHK(k < lim, 1'b1)
        if (k >= lim) begin
            complete_run();
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        seed = 32'h884171a9;
        fail_count = 0;
        check_count = 0;
        sfrAddr = 8'h00;
        sfrWrData = 8'h00;
        sfrWrEn = 1'b0;
        sfrRdEn = 1'b0;
        timerTick = 1'b1;
        baudReloadValue = 8'hFC;
        nineMode = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        rd(ASP_CTRL_ADDR, v);
        `CHK(v, ASP_CTRL_RESET)
        rd(ASP_DATA_ADDR, v);
        `CHK(v, ASP_DATA_RESET)
        wr(8'h97, 8'hFF);
        rd(8'h97, v);
        `CHK(v, 8'h00)
        wr(ASP_CTRL_ADDR, 8'h00);
        rd(ASP_CTRL_ADDR, v);
        `CHK(v, 8'h40)
        $display("registers done");
        for (int i = 0; i < 3; i++) begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            wr(ASP_DATA_ADDR, b);
            // first wait also covers the timer's first wrap from reset
            wait_for(0, 20 * BIT + ASP_TIMER_WRAP);
            `CHK(asp_remote_model_i.gotQ.size(), 0)
            repeat (2) @(posedge clk);
            #1;
            `CHK(txPin, 1'b1)
            wait_for(1, 4 * BIT);
            got = asp_remote_model_i.gotQ.pop_front();
            `CHK(got, {1'b1, b})
            repeat (20 * BIT) @(posedge clk);
            #1;
            `CHK(irq, 1'b1)
            rd(ASP_CTRL_ADDR, v);
            `CHK(v[1:0], 2'b10)
            wr(ASP_CTRL_ADDR, 8'h00);
            `CHK(irq, 1'b0)
        end
        $display("transmit done");
        n = 0;
        while (txAccept === 1'b1 && n < 20) begin
            wr(ASP_DATA_ADDR, 8'(n + 8'hA0));
            n++;
        end
        `CHK(n >= 8, 1'b1)
        wr(ASP_DATA_ADDR, 8'h5A);
        wait_for(n, 12 * BIT * (n + 1));
        for (int i = 0; i < n; i++) begin
            got = asp_remote_model_i.gotQ.pop_front();
            `CHK(got, {1'b1, 8'(i + 8'hA0)})
        end
        repeat (24 * BIT) @(posedge clk);
        `CHK(asp_remote_model_i.gotQ.size(), 0)
        $display("buffer done");
        wr(ASP_CTRL_ADDR, 8'h10);
        b = 8'($random(seed));
        asp_remote_model_i.send(b, 1'b0, 1'b0, 1'b1);
        `CHK(irq, 1'b1)
        rd(ASP_CTRL_ADDR, v);
        `CHK(v, 8'h55)
        rd(ASP_DATA_ADDR, v);
        `CHK(v, b)
        held = b;
        asp_remote_model_i.send(~b, 1'b0, 1'b0, 1'b1);
        rd(ASP_DATA_ADDR, v);
        `CHK(v, held)
        $display("receive done");
        for (int i = 0; i < 7; i++) begin
            c = CASE_TBL[i];
            wr(ASP_CTRL_ADDR, c[12:5]);
            b = 8'($random(seed));
            asp_remote_model_i.send(b, c[4], c[3], c[2]);
            repeat (2 * BIT) @(posedge clk);
            if (c[1]) begin
                held = b;
            end
            rd(ASP_CTRL_ADDR, v);
            `CHK(v, c[12:5] | 8'h40 | {5'h0, c[0], 1'b0, c[1]})
            rd(ASP_DATA_ADDR, v);
            `CHK(v, held)
        end
        $display("qualify done");
        for (int i = 0; i < 3; i++) begin
            c[12:5] = (i == 0) ? 8'h88 : (i == 1) ? 8'h80 : 8'h08;
            nineMode = c[12];
            wr(ASP_CTRL_ADDR, c[12:5]);
            b = 8'($random(seed));
            wr(ASP_DATA_ADDR, b);
            wait_for(1, 16 * BIT);
            got = asp_remote_model_i.gotQ.pop_front();
            `CHK(got, {c[12] ? c[8] : 1'b1, b})
        end
        $display("ninth bit done");
        complete_run();
    end
endmodule
